// ===== verilog/eepr_dev.sv
`include "eepr_map.svh"

module eepr_dev #(
  parameter int PULSE_MS = `EEPR_PULSE_MS,
  parameter int PULSE_CYCLES = PULSE_MS * `EEPR_CLK_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link side
  eepr_link_if.dev link,
  // array preload
  input wire logic ld_en,
  input wire logic [`EEPR_ADDR_W-1:0] ld_addr,
  input wire logic [7:0] ld_data,
  // status
  output logic mem_disabled,
  output logic rst_pulse
);

  localparam logic [`EEPR_CNT_W-1:0] PULSE_LAST = `EEPR_CNT_W'(PULSE_CYCLES - 1);

  logic [7:0] mem [0:`EEPR_MEM_DEPTH-1];
  eepr_pkg::eepr_dev_state_t r_reg;
  eepr_pkg::eepr_dev_state_t r_next;
  logic [7:0] rd_byte;

  // array contents come from the user-side preload; writes over the link are not served
  always_ff @(posedge clk) begin
    if (ld_en) begin
      mem[ld_addr] <= ld_data;
    end
  end

  assign rd_byte = mem[r_reg.addr];

  always_comb begin
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic hi_edge;
    logic lo_edge;
    logic dis;
    scl = 1'b0;
    sda = 1'b0;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    hi_edge = 1'b0;
    lo_edge = 1'b0;
    dis = 1'b0;
    r_next = r_reg;

    // two-stage synchronisers; only stage two and its delayed copy are read
    r_next.sync1 = {link.scl, link.sda, link.rst_hi, link.rst_lo_n};
    r_next.sync2 = r_reg.sync1;
    r_next.prev = r_reg.sync2;
    scl = r_reg.sync2[`EEPR_I_SCL];
    sda = r_reg.sync2[`EEPR_I_SDA];
    scl_rise = scl & !r_reg.prev[`EEPR_I_SCL];
    scl_fall = !scl & r_reg.prev[`EEPR_I_SCL];
    start_c = scl & r_reg.prev[`EEPR_I_SCL] & r_reg.prev[`EEPR_I_SDA] & !sda;
    stop_c = scl & r_reg.prev[`EEPR_I_SCL] & !r_reg.prev[`EEPR_I_SDA] & sda;

    // active edges only; own drive is masked so the read-back cannot retrigger
    hi_edge = r_reg.sync2[`EEPR_I_HI] & !r_reg.prev[`EEPR_I_HI] & !r_reg.drv_hi;
    lo_edge = !r_reg.sync2[`EEPR_I_LO] & r_reg.prev[`EEPR_I_LO] & !r_reg.drv_lo;

    // pulse timer: a new edge restarts it, expiry ends it however long the input stays
    if (hi_edge) begin
      r_next.drv_lo = 1'b1;
      r_next.drv_hi = 1'b0;
      r_next.cnt = PULSE_LAST;
    end else if (lo_edge) begin
      r_next.drv_hi = 1'b1;
      r_next.drv_lo = 1'b0;
      r_next.cnt = PULSE_LAST;
    end else if (r_reg.drv_hi | r_reg.drv_lo) begin
      if (r_reg.cnt == '0) begin
        r_next.drv_hi = 1'b0;
        r_next.drv_lo = 1'b0;
      end else begin
        r_next.cnt = r_reg.cnt - 1'b1;
      end
    end

    // any reset level on either pin, own pulse included, shuts the memory off
    dis = r_reg.sync2[`EEPR_I_HI] | !r_reg.sync2[`EEPR_I_LO];
    r_next.disabled = dis;

    if (dis) begin
      r_next.st = eepr_pkg::DEV_IDLE;
      r_next.sda_drv = 1'b0;
    end else if (start_c) begin
      r_next.st = eepr_pkg::DEV_RX;
      r_next.phase = eepr_pkg::PH_DEV;
      r_next.bitcnt = '0;
      r_next.sda_drv = 1'b0;
    end else if (stop_c) begin
      r_next.st = eepr_pkg::DEV_IDLE;
      r_next.sda_drv = 1'b0;
    end else if (scl_rise) begin
      // data sampled while scl is high
      case (r_reg.st)
        eepr_pkg::DEV_RX: begin
          r_next.shreg = {r_reg.shreg[6:0], sda};
          r_next.bitcnt = r_reg.bitcnt + 1'b1;
        end
        eepr_pkg::DEV_TX: begin
          r_next.bitcnt = r_reg.bitcnt + 1'b1;
        end
        eepr_pkg::DEV_RACK: begin
          r_next.got_ack = !sda;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      // sda only changes while scl is low
      case (r_reg.st)
        eepr_pkg::DEV_RX: begin
          if (r_reg.bitcnt == `EEPR_ACK_SLOT) begin
            r_next.bitcnt = '0;
            case (r_reg.phase)
              eepr_pkg::PH_DEV: begin
                if (r_reg.shreg[7:4] == `EEPR_DEV_ID) begin
                  r_next.st = eepr_pkg::DEV_ACK;
                  r_next.sda_drv = 1'b1;
                  r_next.rd = r_reg.shreg[0];
                  r_next.phase = eepr_pkg::PH_WORD;
                  // current-address reads keep the counter, writes load the high bits
                  if (!r_reg.shreg[0]) begin
                    r_next.addr[`EEPR_ADDR_W-1:8] = r_reg.shreg[3:1];
                  end
                end else begin
                  r_next.st = eepr_pkg::DEV_WAIT;
                end
              end
              eepr_pkg::PH_WORD: begin
                r_next.addr[7:0] = r_reg.shreg;
                r_next.st = eepr_pkg::DEV_ACK;
                r_next.sda_drv = 1'b1;
                r_next.phase = eepr_pkg::PH_DATA;
              end
              default: begin
                // write data is not served: refuse it
                r_next.st = eepr_pkg::DEV_WAIT;
              end
            endcase
          end
        end
        eepr_pkg::DEV_ACK: begin
          if (r_reg.rd) begin
            r_next.st = eepr_pkg::DEV_TX;
            r_next.shreg = rd_byte;
            r_next.sda_drv = !rd_byte[7];
            r_next.addr = r_reg.addr + 1'b1;
            r_next.bitcnt = '0;
          end else begin
            r_next.st = eepr_pkg::DEV_RX;
            r_next.sda_drv = 1'b0;
          end
        end
        eepr_pkg::DEV_TX: begin
          if (r_reg.bitcnt == `EEPR_ACK_SLOT) begin
            r_next.sda_drv = 1'b0;
            r_next.got_ack = 1'b0;
            r_next.st = eepr_pkg::DEV_RACK;
          end else begin
            r_next.sda_drv = !r_reg.shreg[6];
            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
          end
        end
        eepr_pkg::DEV_RACK: begin
          if (r_reg.got_ack) begin
            // 11-bit counter rolls 2047 -> 0 on its own
            r_next.st = eepr_pkg::DEV_TX;
            r_next.shreg = rd_byte;
            r_next.sda_drv = !rd_byte[7];
            r_next.addr = r_reg.addr + 1'b1;
            r_next.bitcnt = '0;
          end else begin
            r_next.st = eepr_pkg::DEV_WAIT;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // single state register; pin synchronisers reset to the idle bus levels
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '{sync1: `EEPR_PINS_IDLE, sync2: `EEPR_PINS_IDLE, prev: `EEPR_PINS_IDLE,
                 st: eepr_pkg::DEV_IDLE, phase: eepr_pkg::PH_DEV, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // open-drain drivers: only ever pull toward the active level
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = r_reg.sda_drv;
  assign link.dev_rhi_o = 1'b1;
  assign link.dev_rhi_oe = r_reg.drv_hi;
  assign link.dev_rlo_o = 1'b0;
  assign link.dev_rlo_oe = r_reg.drv_lo;
  assign mem_disabled = r_reg.disabled;
  assign rst_pulse = r_reg.drv_hi | r_reg.drv_lo;

endmodule

// ===== verilog/eepr_map.svh
// Function
// - master dummy-writes word address before random read
// - master repeats start and address with read
// - device acks read address, shifts out byte
// - master ends single read with nack, stop
// - sequential read follows current or random read
// - one more byte per master ack
// - sequential bytes from consecutive addresses
// - counter wraps from 2047 to zero
// - only the active reset-pin edge is sensed
// - edge starts 200 ms complementary reset pulse
// - pulse ends after 200 ms regardless
// - memory disabled while either pin in reset
// - no ack while manual reset stays asserted
// - respond only to device code 1010
// - counter holds last address plus one
// - release data, sample ack, nack waits stop
`ifndef EEPR_MAP_SVH
`define EEPR_MAP_SVH

// slave address layout
`define EEPR_DEV_ID 4'ha
`define EEPR_ACK_SLOT 4'h8
`define EEPR_ADDR_W 11
`define EEPR_MEM_DEPTH 2048

// reset pulse timing
`define EEPR_PULSE_MS 200
`define EEPR_CLK_KHZ 250000
`define EEPR_CNT_W 26

// host scl quarter period in clk cycles (10 cycles = 40 ns)
`define EEPR_SCL_QTR 8'h0a
`define EEPR_DIV_W 8

// sampled pin vector {scl, sda, rst_hi, rst_lo_n} and its idle value
`define EEPR_I_SCL 3
`define EEPR_I_SDA 2
`define EEPR_I_HI 1
`define EEPR_I_LO 0
`define EEPR_PINS_IDLE 4'hd

`endif

// ===== verilog/eepr_pkg.sv
`include "eepr_map.svh"

package eepr_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE, DEV_RX, DEV_ACK, DEV_TX, DEV_RACK, DEV_WAIT
  } eepr_dev_st_t;

  typedef enum logic [1:0] {
    PH_DEV, PH_WORD, PH_DATA
  } eepr_phase_t;

  typedef enum logic [1:0] {
    H_IDLE, H_START, H_BYTE, H_STOP
  } eepr_host_st_t;

  typedef enum logic [1:0] {
    STEP_DEVW, STEP_WORD, STEP_DEVR, STEP_DATA
  } eepr_step_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    eepr_dev_st_t st;
    eepr_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rd;
    logic got_ack;
    logic sda_drv;
    logic [`EEPR_ADDR_W-1:0] addr;
    logic drv_hi;
    logic drv_lo;
    logic [`EEPR_CNT_W-1:0] cnt;
    logic disabled;
  } eepr_dev_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [`EEPR_DIV_W-1:0] div;
    logic [1:0] q;
    eepr_host_st_t st;
    eepr_step_t step;
    logic [3:0] bitidx;
    logic [7:0] shreg;
    logic nak;
    logic scl;
    logic sda_drv;
    logic [11:0] rem;
    logic rnd;
    logic [`EEPR_ADDR_W-1:0] addr;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic err;
  } eepr_host_state_t;

endpackage

// ===== verilog/eepr_link_if.sv
// two-wire link plus the two reset pins, wired-and / wired-or resolved here
interface eepr_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  logic host_rhi_o;
  logic host_rhi_oe;
  logic dev_rhi_o;
  logic dev_rhi_oe;
  logic rst_hi;
  logic host_rlo_o;
  logic host_rlo_oe;
  logic dev_rlo_o;
  logic dev_rlo_oe;
  logic rst_lo_n;

  // open drain with pull-up on sda and rst_lo_n, pull-down on rst_hi
  assign sda = !((host_sda_oe & !host_sda_o) | (dev_sda_oe & !dev_sda_o));
  assign rst_hi = (host_rhi_oe & host_rhi_o) | (dev_rhi_oe & dev_rhi_o);
  assign rst_lo_n = !((host_rlo_oe & !host_rlo_o) | (dev_rlo_oe & !dev_rlo_o));

  modport host (
    output scl, host_sda_o, host_sda_oe, host_rhi_o, host_rhi_oe,
    output host_rlo_o, host_rlo_oe,
    input sda, rst_hi, rst_lo_n
  );

  modport dev (
    output dev_sda_o, dev_sda_oe, dev_rhi_o, dev_rhi_oe, dev_rlo_o, dev_rlo_oe,
    input scl, sda, rst_hi, rst_lo_n
  );
endinterface

// ===== verilog/eepr_host.sv
`include "eepr_map.svh"

module eepr_host (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link side
  eepr_link_if.host link,
  // read command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_random,
  input wire logic [`EEPR_ADDR_W-1:0] cmd_addr,
  input wire logic [11:0] cmd_len,
  // read results
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic err,
  // manual reset buttons
  input wire logic mr_hi_press,
  input wire logic mr_lo_press
);

  eepr_pkg::eepr_host_state_t r_reg;
  eepr_pkg::eepr_host_state_t r_next;

  always_comb begin
    logic tick;
    logic tx;
    logic sda;
    tick = (r_reg.div == `EEPR_SCL_QTR - 1'b1);
    tx = (r_reg.step != eepr_pkg::STEP_DATA);
    sda = r_reg.sync2;
    r_next = r_reg;
    r_next.sync1 = link.sda;
    r_next.sync2 = r_reg.sync1;
    r_next.rd_valid = 1'b0;
    r_next.done = 1'b0;
    r_next.div = tick ? '0 : r_reg.div + 1'b1;

    if (r_reg.st == eepr_pkg::H_IDLE) begin
      r_next.scl = 1'b1;
      r_next.sda_drv = 1'b0;
      if (cmd_valid) begin
        r_next.st = eepr_pkg::H_START;
        r_next.step = cmd_random ? eepr_pkg::STEP_DEVW : eepr_pkg::STEP_DEVR;
        r_next.rnd = cmd_random;
        r_next.addr = cmd_addr;
        r_next.rem = (cmd_len == '0) ? 12'h001 : cmd_len;
        r_next.err = 1'b0;
        r_next.q = '0;
        r_next.div = '0;
      end
    end else if (tick) begin
      r_next.q = r_reg.q + 1'b1;
      case (r_reg.st)
        eepr_pkg::H_START: begin
          // also serves as the repeated start
          case (r_reg.q)
            2'h0: begin
              r_next.scl = 1'b0;
              r_next.sda_drv = 1'b0;
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: r_next.sda_drv = 1'b1;
            default: begin
              r_next.scl = 1'b0;
              r_next.st = eepr_pkg::H_BYTE;
              r_next.bitidx = '0;
              r_next.shreg = {`EEPR_DEV_ID, r_reg.addr[`EEPR_ADDR_W-1:8],
                              r_reg.step == eepr_pkg::STEP_DEVR};
            end
          endcase
        end
        eepr_pkg::H_BYTE: begin
          case (r_reg.q)
            2'h0: begin
              if (r_reg.bitidx != `EEPR_ACK_SLOT) begin
                r_next.sda_drv = tx & !r_reg.shreg[7];
              end else begin
                // ack every received data byte but the last, then nack; sent bytes release sda
                r_next.sda_drv = !tx & (r_reg.rem != 12'h001);
              end
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: begin
              if (r_reg.bitidx != `EEPR_ACK_SLOT) begin
                r_next.shreg = {r_reg.shreg[6:0], tx ? 1'b0 : sda};
              end else begin
                r_next.nak = tx & sda;
              end
            end
            default: begin
              r_next.scl = 1'b0;
              r_next.bitidx = r_reg.bitidx + 1'b1;
              if (r_reg.bitidx == `EEPR_ACK_SLOT) begin
                r_next.bitidx = '0;
                if (r_reg.nak) begin
                  r_next.err = 1'b1;
                  r_next.st = eepr_pkg::H_STOP;
                end else begin
                  case (r_reg.step)
                    eepr_pkg::STEP_DEVW: begin
                      r_next.step = eepr_pkg::STEP_WORD;
                      r_next.shreg = r_reg.addr[7:0];
                    end
                    eepr_pkg::STEP_WORD: begin
                      r_next.step = eepr_pkg::STEP_DEVR;
                      r_next.st = eepr_pkg::H_START;
                    end
                    eepr_pkg::STEP_DEVR: r_next.step = eepr_pkg::STEP_DATA;
                    default: begin
                      r_next.rd_data = r_reg.shreg;
                      r_next.rd_valid = 1'b1;
                      r_next.rem = r_reg.rem - 1'b1;
                      if (r_reg.rem == 12'h001) begin
                        r_next.st = eepr_pkg::H_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        eepr_pkg::H_STOP: begin
          case (r_reg.q)
            2'h0: r_next.sda_drv = 1'b1;
            2'h1: r_next.scl = 1'b1;
            2'h2: r_next.sda_drv = 1'b0;
            default: begin
              r_next.st = eepr_pkg::H_IDLE;
              r_next.done = 1'b1;
            end
          endcase
        end
        default: r_next.st = eepr_pkg::H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '{sync1: 1'b1, sync2: 1'b1, scl: 1'b1, st: eepr_pkg::H_IDLE,
                 step: eepr_pkg::STEP_DEVW, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // scl is push-pull from the only master; sda open drain
  assign cmd_ready = (r_reg.st == eepr_pkg::H_IDLE);
  assign link.scl = r_reg.scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = r_reg.sda_drv;
  assign link.host_rhi_o = 1'b1;
  assign link.host_rhi_oe = mr_hi_press;
  assign link.host_rlo_o = 1'b0;
  assign link.host_rlo_oe = mr_lo_press;
  assign rd_valid = r_reg.rd_valid;
  assign rd_data = r_reg.rd_data;
  assign done = r_reg.done;
  assign err = r_reg.err;

endmodule

// ===== test/eepr_link_props.sv
module eepr_link_props #(
  parameter int PULSE_CYCLES = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link pins
  input wire logic scl,
  input wire logic dev_sda_oe,
  // reset pins
  input wire logic rst_hi,
  input wire logic rst_lo_n,
  input wire logic dev_rhi_oe,
  input wire logic dev_rlo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pulse;
  logic [15:0] pcnt_reg;
  logic [7:0] low_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // either complementary pin counts as the pulse
  assign pulse = dev_rhi_oe | dev_rlo_oe;

  // run length of the pulse; scl low time, saturating so it never wraps
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcnt_reg <= 16'h0000;
      low_reg <= 8'h00;
    end else begin
      pcnt_reg <= pulse ? pcnt_reg + 16'h0001 : 16'h0000;
      low_reg <= scl ? 8'h00 : ((low_reg == 8'hff) ? low_reg : low_reg + 8'h01);
    end
  end

  // synchroniser delay plus abort, so six cycles of reset level
  sequence s_rst;
    (rst_hi || !rst_lo_n) [*6];
  endsequence

  property p_hi_edge;
    $rose(rst_hi) && !dev_rhi_oe |-> ##[2:5] dev_rlo_oe;
  endproperty
  a_hi_edge: assert property (p_hi_edge) else $error("no low pulse after high press");

  property p_lo_edge;
    $fell(rst_lo_n) && !dev_rlo_oe |-> ##[2:5] dev_rhi_oe;
  endproperty
  a_lo_edge: assert property (p_lo_edge) else $error("no high pulse after low press");

  property p_pulse_len;
    $fell(pulse) |-> pcnt_reg == 16'(PULSE_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

  property p_pulse_max;
    pcnt_reg <= 16'(PULSE_CYCLES);
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("reset pulse too long");

  property p_hold;
    $rose(pulse) |=> pulse [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("reset pulse dropped early");

  property p_no_retrig;
    $rose(rst_lo_n) && !pulse |=> !pulse [*6];
  endproperty
  a_no_retrig: assert property (p_no_retrig) else $error("inactive edge made a pulse");

  property p_disabled;
    s_rst |-> !dev_sda_oe;
  endproperty
  a_disabled: assert property (p_disabled) else $error("sda driven while in reset");

  property p_sda_time;
    $changed(dev_sda_oe) |-> !scl && low_reg >= 8'h02 && low_reg <= 8'h07;
  endproperty
  a_sda_time: assert property (p_sda_time) else $error("sda moved outside scl low");

  c_pulse: cover property ($fell(pulse));
  c_ack: cover property ($rose(dev_sda_oe));
  c_dis: cover property (s_rst ##1 rst_lo_n);
endmodule

// ===== test/eeprom_read_and_manual_reset_tb.sv
`include "eepr_map.svh"

module eeprom_read_and_manual_reset_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // short pulse count keeps the run brief
  localparam int PULSE = 50;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ld_en = 1'b0;
  logic [`EEPR_ADDR_W-1:0] ld_addr = 11'h000;
  logic [7:0] ld_data = 8'h00;
  logic cmd_valid = 1'b0;
  logic cmd_random = 1'b0;
  logic [`EEPR_ADDR_W-1:0] cmd_addr = 11'h000;
  logic [11:0] cmd_len = 12'h001;
  logic mr_hi_press = 1'b0;
  logic mr_lo_press = 1'b0;
  logic mem_disabled, rst_pulse, cmd_ready, rd_valid, done, err;
  logic [7:0] rd_data;
  logic [31:0] seed = 32'hee97;
  logic [7:0] mem [`EEPR_MEM_DEPTH];
  int ptr = 0;
  int num_errors = 0;
  int tests_run = 0;

  always #2 clk = !clk;

  eepr_link_if i_eepr_link_if ();
  eepr_dev #(.PULSE_CYCLES(PULSE)) i_eepr_dev (.clk(clk), .sys_rst(sys_rst),
    .link(i_eepr_link_if), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
    .mem_disabled(mem_disabled), .rst_pulse(rst_pulse));
  eepr_host i_eepr_host (.clk(clk), .sys_rst(sys_rst), .link(i_eepr_link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_random(cmd_random),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .err(err), .mr_hi_press(mr_hi_press), .mr_lo_press(mr_lo_press));
  eepr_link_props #(.PULSE_CYCLES(PULSE)) i_eepr_link_props (.clk(clk), .sys_rst(sys_rst),
    .scl(i_eepr_link_if.scl), .dev_sda_oe(i_eepr_link_if.dev_sda_oe),
    .rst_hi(i_eepr_link_if.rst_hi), .rst_lo_n(i_eepr_link_if.rst_lo_n),
    .dev_rhi_oe(i_eepr_link_if.dev_rhi_oe), .dev_rlo_oe(i_eepr_link_if.dev_rlo_oe));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      num_errors++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  // one read command; the model pointer follows the device counter
  task automatic rd(input logic rnd, input int a, input int n, input logic e);
    int got;
    logic fin;
    got = 0;
    fin = 1'b0;
    @(negedge clk);
    for (int w = 0; w < 100 && cmd_ready !== 1'b1; w++) @(negedge clk);
    cmd_valid = 1'b1;
    cmd_random = rnd;
    cmd_addr = a[10:0];
    cmd_len = n[11:0];
    @(negedge clk);
    cmd_valid = 1'b0;
    if (rnd && !e) ptr = a;
    for (int w = 0; w < 8000 && !fin; w++) begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) begin
        chk8(rd_data, mem[ptr]);
        ptr = (ptr + 1) % `EEPR_MEM_DEPTH;
        got++;
      end
      fin = (done === 1'b1);
    end
    chk1(fin, 1'b1);
    chk1(cmd_ready, 1'b1);
    chkn(got, e ? 0 : n);
    chk1(err, e);
  endtask

  // length of the complementary pulse, with the memory disabled inside it
  task automatic pulse_len();
    int n;
    n = 0;
    for (int w = 0; w < 20 && rst_pulse !== 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    while (rst_pulse === 1'b1 && n < 1000) begin
      if (n == 4) chk1(mem_disabled, 1'b1);
      n++;
      @(posedge clk);
      #1;
    end
    chkn(n, PULSE);
  endtask

  // main sequence: preload, reads, then both kinds of manual reset
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < `EEPR_MEM_DEPTH; i++) begin
      @(negedge clk);
      seed = lfsr(seed);
      ld_en = 1'b1;
      ld_addr = i[10:0];
      ld_data = seed[7:0];
      mem[i] = seed[7:0];
    end
    @(negedge clk);
    ld_en = 1'b0;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      rd(1'b1, int'(seed[10:0]), int'(seed[13:12]) + 1, 1'b0);
    end
    rd(1'b1, 2046, 4, 1'b0);
    rd(1'b0, 0, 2, 1'b0);
    @(negedge clk);
    mr_hi_press = 1'b1;
    // released well before the pulse ends
    fork
      begin
        repeat (10) @(negedge clk);
        mr_hi_press = 1'b0;
      end
    join_none
    pulse_len();
    rd(1'b0, 0, 1, 1'b0);
    @(negedge clk);
    mr_lo_press = 1'b1;
    pulse_len();
    rd(1'b1, 100, 1, 1'b1);
    @(negedge clk);
    mr_lo_press = 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1;
      chk1(rst_pulse, 1'b0);
    end
    chk1(mem_disabled, 1'b0);
    rd(1'b1, 2047, 2, 1'b0);
    end_of_test();
  end

  // hang guard, well beyond the expected run
  initial begin
    #300000;
    num_errors++;
    end_of_test();
  end
endmodule
